// ===== verilog/dbim_top.sv
// Overview of operation
// - Non-debug access to debug window gets error.
// - Debug masters otherwise share the common map.
// - Four debug unit regions, 16 MiB apart.
// - Debug peripheral bridge decodes its three slaves.
// - Trace buffer occupies 128 KiB at its base.
// - Debug bus and debug peripheral config areas.
// - Memory bus registers and config area decoded.
// - Processor bus and second bridge config areas.
// - Line 10 follows any of lines 15-31.
// - Line 15 unmaskable and never driven.
// - Timer lines 1-5 separate, 6-9 shared.
// - Port lines 16-19, 19 shared with serial.
// - Lines 20-31 go to listed peripherals.
// - Line 11 combines PCI bridge and DMA.
// - Master I/O bus has fixed indexes 0-8.
// - Debug masters 0-4 with 32-byte records.
// - Debug slaves 0-3 with 32-byte records.
// - Debug peripherals 0-2 with 8-byte records.
// - Memory masters 0-2 with 32-byte records.
`timescale 1ns/1ps

module dbim_top
  import dbim_pkg::*;
(
  input  wire logic          i_clock,    // System clock, 100 MHz.
  input  wire logic          i_rst_b,    // Asynchronous reset, active low.
  input  wire logic          i_clk_en,   // Freezes all state while low.
  input  wire dbim_req_s     i_req,      // Address to decode.
  input  wire dbim_irq_src_s i_irq_src,  // Peripheral interrupt requests.
  output dbim_dec_s          o_dec,      // Registered decode result.
  output logic [31:0]        o_irq       // Registered interrupt lines.
);

  //////////////////////////////////////////////////////////////////////////////
  // Helper functions.
  //////////////////////////////////////////////////////////////////////////////

  // True when the address lies inside an inclusive range.  Used for every
  // window in the map but the debug unit regions, so each range is written once in the package.
  function automatic logic in_rng
  (
    input logic [31:0] a,
    input logic [31:0] lo,
    input logic [31:0] hi
  );
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  // Number of masters attached to a bus; indexes at or above it are
  // refused, which keeps an index from a miswired master from slipping by.
  function automatic logic [3:0] mst_count(input dbim_bus_e b);
    case (b)
      DBIM_BUS_PROC: mst_count = DBIM_NMST_PROC;
      DBIM_BUS_MEM:  mst_count = DBIM_NMST_MEM;
      DBIM_BUS_DBG:  mst_count = DBIM_NMST_DBG;
      default:       mst_count = DBIM_NMST_MIO;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Global map decode, common to every bus.
  //////////////////////////////////////////////////////////////////////////////

  dbim_tgt_e glb_tgt;   // Target in the common map.
  logic [5:0] glb_unit; // Record index within a config area.
  logic       glb_rec;  // Address falls on a valid record.
  logic       glb_slv;  // Record is in the slave half of an area.

  // Decode the part of the map that all masters see alike.  Any range not
  // listed here is unused and leaves the target at none.
  always_comb
  begin
    glb_tgt  = DBIM_T_NONE;
    glb_unit = 6'h00;
    glb_rec  = 1'b0;
    glb_slv  = i_req.addr[DBIM_SLV_BIT];
    if (in_rng(i_req.addr, DBIM_L2MEM_LO, DBIM_L2MEM_HI))
      glb_tgt = DBIM_T_L2MEM;
    else if (in_rng(i_req.addr, DBIM_PCIMEM_LO, DBIM_PCIMEM_HI))
      glb_tgt = DBIM_T_PCIMEM;
    else if (in_rng(i_req.addr, DBIM_PROM_LO, DBIM_PROM_HI))
      glb_tgt = DBIM_T_PROM;
    else if (in_rng(i_req.addr, DBIM_MMIO_LO, DBIM_MMIO_HI))
      glb_tgt = DBIM_T_MMIO;
    else if (in_rng(i_req.addr, DBIM_L2CFG_LO, DBIM_L2CFG_HI))
      glb_tgt = DBIM_T_L2CFG;
    else if (in_rng(i_req.addr, DBIM_PCIIO_LO, DBIM_PCIIO_HI))
      glb_tgt = DBIM_T_PCIIO;
    else if (in_rng(i_req.addr, DBIM_IOMMU_LO, DBIM_IOMMU_HI))
      glb_tgt = DBIM_T_IOMMU;
    else if (in_rng(i_req.addr, DBIM_ROUTER_LO, DBIM_ROUTER_HI))
      glb_tgt = DBIM_T_ROUTER;
    else if (in_rng(i_req.addr, DBIM_SIOPNP_LO, DBIM_SIOPNP_HI))
      glb_tgt = DBIM_T_SIOPNP;
    else if (in_rng(i_req.addr, DBIM_APB0_LO, DBIM_APB0_HI) ||
             in_rng(i_req.addr, DBIM_APB0PNP_LO, DBIM_APB0PNP_HI))
      glb_tgt = DBIM_T_APB0;
    else if (in_rng(i_req.addr, DBIM_APB1_LO, DBIM_APB1_HI))
      glb_tgt = DBIM_T_APB1;
    else if (in_rng(i_req.addr, DBIM_APB1PNP_LO, DBIM_APB1PNP_HI))
      glb_tgt = DBIM_T_APB1PNP;
    else if (in_rng(i_req.addr, DBIM_SDRAM_LO, DBIM_SDRAM_HI))
      glb_tgt = DBIM_T_SDRAM;
    else if (in_rng(i_req.addr, DBIM_SCRUB_LO, DBIM_SCRUB_HI))
      glb_tgt = DBIM_T_SCRUB;
    else if (in_rng(i_req.addr, DBIM_MEMPNP_LO, DBIM_MEMPNP_HI))
    begin
      // Memory bus masters hold the first three 32-byte records.
      glb_tgt  = DBIM_T_MEMPNP;
      glb_unit = i_req.addr[10:5];
      glb_rec  = !glb_slv && (i_req.addr[10:5] < DBIM_NREC_MEMM);
    end
    else if (in_rng(i_req.addr, DBIM_PRCPNP_LO, DBIM_PRCPNP_HI))
      glb_tgt = DBIM_T_PRCPNP;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Debug-only window decode.
  //////////////////////////////////////////////////////////////////////////////

  dbim_tgt_e dbg_tgt;   // Target inside the debug window.
  logic [5:0] dbg_unit; // Processor or record index.
  logic       dbg_rec;  // Address falls on a valid record.
  logic [31:0] dsu_off; // Address relative to its processor's region.

  // Each processor's region starts on a 16 MiB step; only its low 8 MiB
  // is populated, so the offset inside the step decides the hit.
  assign dsu_off = i_req.addr - (DBIM_DWIN_LO + {6'h00, i_req.addr[25:24],
                                                  24'h00_0000});

  // Decode the debug window.  The slave/master split of the debug bus
  // config area uses the same bit as the other bus areas.
  always_comb
  begin
    dbg_tgt  = DBIM_T_NONE;
    dbg_unit = 6'h00;
    dbg_rec  = 1'b0;
    if ((i_req.addr[27:26] == 2'b00) && (dsu_off <= DBIM_DSU_SPAN))
    begin
      // Processors 0 to 3 occupy the first four steps.
      dbg_tgt  = DBIM_T_DSU;
      dbg_unit = {4'h0, i_req.addr[25:24]};
      dbg_rec  = ({1'b0, i_req.addr[25:24]} < DBIM_NCPU);
    end
    else if (in_rng(i_req.addr, DBIM_SPW_LO, DBIM_SPW_HI))
      dbg_tgt = DBIM_T_DSPW;
    else if (in_rng(i_req.addr, DBIM_STAT_LO, DBIM_STAT_HI))
      dbg_tgt = DBIM_T_DSTAT;
    else if (in_rng(i_req.addr, DBIM_PTRC_LO, DBIM_PTRC_HI))
      dbg_tgt = DBIM_T_DPTRC;
    else if (in_rng(i_req.addr, DBIM_DAREC_LO, DBIM_DAREC_HI))
    begin
      // Peripheral records are eight bytes each.
      dbg_tgt  = DBIM_T_DAPNP;
      dbg_unit = {3'h0, i_req.addr[5:3]};
      dbg_rec  = ({3'h0, i_req.addr[5:3]} < DBIM_NREC_DAPB);
    end
    else if (in_rng(i_req.addr, DBIM_DAPNP_LO, DBIM_DAPNP_HI))
      dbg_tgt = DBIM_T_DAPNP;
    else if (in_rng(i_req.addr, DBIM_TRACE_LO, DBIM_TRACE_HI))
      dbg_tgt = DBIM_T_TRACE;
    else if (in_rng(i_req.addr, DBIM_DBGPNP_LO, DBIM_DBGPNP_HI))
    begin
      // Masters fill the low half, slaves the upper half, 32 bytes each.
      dbg_tgt  = DBIM_T_DBGPNP;
      dbg_unit = i_req.addr[10:5];
      if (i_req.addr[DBIM_SLV_BIT])
        dbg_rec = (i_req.addr[10:5] < DBIM_NREC_DBGS);
      else
        dbg_rec = (i_req.addr[10:5] < DBIM_NREC_DBGM);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Result selection and error policy.
  //////////////////////////////////////////////////////////////////////////////

  dbim_dec_s dec_r;    // Registered result.
  dbim_dec_s dec_nxt;  // Next result.
  logic      in_dwin;  // Address lies in the debug-only window.
  logic      mst_bad;  // Master index outside the bus's population.

  assign in_dwin = in_rng(i_req.addr, DBIM_DWIN_LO, DBIM_DWIN_HI);
  assign mst_bad = (i_req.mst >= mst_count(i_req.bus));

  // Pick the window that applies to the requesting bus.  The debug window
  // is routed only for debug masters; everyone else, including the master
  // I/O bus, gets an error there instead of a silent completion.  A request
  // that is not valid leaves a cleared result so stale targets never linger.
  always_comb
  begin
    dec_nxt     = DBIM_DEC_RST;
    dec_nxt.vld = i_req.vld;
    if (i_req.vld)
    begin
      if (in_dwin && (i_req.bus != DBIM_BUS_DBG))
        dec_nxt.err = 1'b1;
      else if (in_dwin)
      begin
        dec_nxt.tgt  = dbg_tgt;
        dec_nxt.unit = dbg_unit;
        dec_nxt.rec  = dbg_rec;
        dec_nxt.slv  = i_req.addr[DBIM_SLV_BIT] &&
                       (dbg_tgt == DBIM_T_DBGPNP);
        dec_nxt.err  = (dbg_tgt == DBIM_T_NONE);
      end
      else
      begin
        // Outside the window a debug master sees the shared map.
        dec_nxt.tgt  = glb_tgt;
        dec_nxt.unit = glb_unit;
        dec_nxt.rec  = glb_rec;
        dec_nxt.slv  = glb_slv && (glb_tgt == DBIM_T_MEMPNP);
        dec_nxt.err  = (glb_tgt == DBIM_T_NONE);
      end
      // An unknown master index is refused whatever it addressed.
      if (mst_bad)
        dec_nxt.err = 1'b1;
      if (dec_nxt.err)
        dec_nxt.tgt = DBIM_T_NONE;
    end
  end

  // One stage of registers; the clock enable holds the last result.
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
      dec_r <= DBIM_DEC_RST;
    else if (i_clk_en)
      dec_r <= dec_nxt;
  end

  assign o_dec = dec_r;

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt routing.
  //////////////////////////////////////////////////////////////////////////////

  // The router registers its lines, so o_irq comes straight from flops.
  dbim_irq_map u_irq_map
  (
    .i_clock  (i_clock),
    .i_rst_b  (i_rst_b),
    .i_clk_en (i_clk_en),
    .i_src    (i_irq_src),
    .o_irq    (o_irq)
  );

endmodule

// ===== verilog/dbim_pkg.sv
package dbim_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Bus identities and master counts.
  //////////////////////////////////////////////////////////////////////////////

  // Bus on which a request is raised.
  typedef enum logic [1:0]
  {
    DBIM_BUS_PROC = 2'h0,
    DBIM_BUS_MEM  = 2'h1,
    DBIM_BUS_DBG  = 2'h2,
    DBIM_BUS_MIO  = 2'h3
  } dbim_bus_e;

  // Number of masters present on each bus.
  localparam logic [3:0] DBIM_NMST_PROC = 4'h6;
  localparam logic [3:0] DBIM_NMST_MEM  = 4'h3;
  localparam logic [3:0] DBIM_NMST_DBG  = 4'h5;
  localparam logic [3:0] DBIM_NMST_MIO  = 4'h9;

  //////////////////////////////////////////////////////////////////////////////
  // Address ranges of the global map (lowest and highest byte).
  //////////////////////////////////////////////////////////////////////////////

  localparam logic [31:0] DBIM_L2MEM_LO   = 32'h0000_0000;
  localparam logic [31:0] DBIM_L2MEM_HI   = 32'h7fff_ffff;
  localparam logic [31:0] DBIM_PCIMEM_LO  = 32'h8000_0000;
  localparam logic [31:0] DBIM_PCIMEM_HI  = 32'hbfff_ffff;
  localparam logic [31:0] DBIM_PROM_LO    = 32'hc000_0000;
  localparam logic [31:0] DBIM_PROM_HI    = 32'hcfff_ffff;
  localparam logic [31:0] DBIM_MMIO_LO    = 32'hd000_0000;
  localparam logic [31:0] DBIM_MMIO_HI    = 32'hdfff_ffff;
  localparam logic [31:0] DBIM_DWIN_LO    = 32'he000_0000;
  localparam logic [31:0] DBIM_DWIN_HI    = 32'hefff_ffff;
  localparam logic [31:0] DBIM_L2CFG_LO   = 32'hf000_0000;
  localparam logic [31:0] DBIM_L2CFG_HI   = 32'hf03f_ffff;
  localparam logic [31:0] DBIM_PCIIO_LO   = 32'hff80_0000;
  localparam logic [31:0] DBIM_PCIIO_HI   = 32'hff83_ffff;
  localparam logic [31:0] DBIM_IOMMU_LO   = 32'hff84_0000;
  localparam logic [31:0] DBIM_IOMMU_HI   = 32'hff84_7fff;
  localparam logic [31:0] DBIM_ROUTER_LO  = 32'hff88_0000;
  localparam logic [31:0] DBIM_ROUTER_HI  = 32'hff88_0fff;
  localparam logic [31:0] DBIM_SIOPNP_LO  = 32'hff8f_f000;
  localparam logic [31:0] DBIM_SIOPNP_HI  = 32'hff8f_ffff;
  localparam logic [31:0] DBIM_APB0_LO    = 32'hff90_0000;
  localparam logic [31:0] DBIM_APB0_HI    = 32'hff98_ffff;
  localparam logic [31:0] DBIM_APB0PNP_LO = 32'hff9f_f000;
  localparam logic [31:0] DBIM_APB0PNP_HI = 32'hff9f_ffff;
  localparam logic [31:0] DBIM_APB1_LO    = 32'hffa0_0000;
  localparam logic [31:0] DBIM_APB1_HI    = 32'hffa0_70ff;
  localparam logic [31:0] DBIM_APB1PNP_LO = 32'hffaf_f000;
  localparam logic [31:0] DBIM_APB1PNP_HI = 32'hffaf_ffff;
  localparam logic [31:0] DBIM_SDRAM_LO   = 32'hffe0_0000;
  localparam logic [31:0] DBIM_SDRAM_HI   = 32'hffe0_00ff;
  localparam logic [31:0] DBIM_SCRUB_LO   = 32'hffe0_1000;
  localparam logic [31:0] DBIM_SCRUB_HI   = 32'hffe0_10ff;
  localparam logic [31:0] DBIM_MEMPNP_LO  = 32'hffef_f000;
  localparam logic [31:0] DBIM_MEMPNP_HI  = 32'hffef_ffff;
  localparam logic [31:0] DBIM_PRCPNP_LO  = 32'hffff_f000;
  localparam logic [31:0] DBIM_PRCPNP_HI  = 32'hffff_ffff;

  //////////////////////////////////////////////////////////////////////////////
  // Ranges inside the debug-only window.
  //////////////////////////////////////////////////////////////////////////////

  localparam logic [31:0] DBIM_DSU_SPAN   = 32'h007f_ffff;
  localparam logic [31:0] DBIM_DSU_STEP   = 32'h0100_0000;
  localparam logic [2:0]  DBIM_NCPU       = 3'h4;
  localparam logic [31:0] DBIM_SPW_LO     = 32'he400_0000;
  localparam logic [31:0] DBIM_SPW_HI     = 32'he400_00ff;
  localparam logic [31:0] DBIM_STAT_LO    = 32'he400_0100;
  localparam logic [31:0] DBIM_STAT_HI    = 32'he400_01ff;
  localparam logic [31:0] DBIM_PTRC_LO    = 32'he404_0000;
  localparam logic [31:0] DBIM_PTRC_HI    = 32'he407_ffff;
  localparam logic [31:0] DBIM_DAREC_LO   = 32'he40f_f000;
  localparam logic [31:0] DBIM_DAREC_HI   = 32'he40f_f017;
  localparam logic [31:0] DBIM_DAPNP_LO   = 32'he40f_ff00;
  localparam logic [31:0] DBIM_DAPNP_HI   = 32'he40f_ffff;
  localparam logic [31:0] DBIM_TRACE_LO   = 32'heff0_0000;
  localparam logic [31:0] DBIM_TRACE_HI   = 32'heff1_ffff;
  localparam logic [31:0] DBIM_DBGPNP_LO  = 32'hefff_f000;
  localparam logic [31:0] DBIM_DBGPNP_HI  = 32'hefff_ffff;

  // Plug-and-play record counts; bit 11 of a bus area selects slaves.
  localparam logic [5:0] DBIM_NREC_DBGM  = 6'h05;
  localparam logic [5:0] DBIM_NREC_DBGS  = 6'h04;
  localparam logic [5:0] DBIM_NREC_MEMM  = 6'h03;
  localparam logic [5:0] DBIM_NREC_DAPB  = 6'h03;
  localparam int         DBIM_SLV_BIT    = 11;

  //////////////////////////////////////////////////////////////////////////////
  // Decode result.
  //////////////////////////////////////////////////////////////////////////////

  typedef enum logic [4:0]
  {
    DBIM_T_NONE    = 5'h00,
    DBIM_T_L2MEM   = 5'h01,
    DBIM_T_PCIMEM  = 5'h02,
    DBIM_T_PROM    = 5'h03,
    DBIM_T_MMIO    = 5'h04,
    DBIM_T_L2CFG   = 5'h05,
    DBIM_T_PCIIO   = 5'h06,
    DBIM_T_IOMMU   = 5'h07,
    DBIM_T_ROUTER  = 5'h08,
    DBIM_T_SIOPNP  = 5'h09,
    DBIM_T_APB0    = 5'h0a,
    DBIM_T_APB1    = 5'h0b,
    DBIM_T_APB1PNP = 5'h0c,
    DBIM_T_SDRAM   = 5'h0d,
    DBIM_T_SCRUB   = 5'h0e,
    DBIM_T_MEMPNP  = 5'h0f,
    DBIM_T_PRCPNP  = 5'h10,
    DBIM_T_DSU     = 5'h11,
    DBIM_T_DSPW    = 5'h12,
    DBIM_T_DSTAT   = 5'h13,
    DBIM_T_DPTRC   = 5'h14,
    DBIM_T_DAPNP   = 5'h15,
    DBIM_T_TRACE   = 5'h16,
    DBIM_T_DBGPNP  = 5'h17
  } dbim_tgt_e;

  typedef struct packed
  {
    logic      vld;
    dbim_bus_e bus;
    logic [3:0]  mst;
    logic [31:0] addr;
  } dbim_req_s;

  typedef struct packed
  {
    logic      vld;
    logic      err;
    dbim_tgt_e tgt;
    logic [5:0] unit;
    logic      rec;
    logic      slv;
  } dbim_dec_s;

  localparam dbim_dec_s DBIM_DEC_RST = '0;

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt sources and line numbers.
  //////////////////////////////////////////////////////////////////////////////

  localparam int DBIM_NSTAT = 2;

  typedef struct packed
  {
    logic [4:0]  tmr0;
    logic [15:0] tmr14;
    logic        pci;
    logic        pcidma;
    logic [3:0]  gpio;
    logic        spi;
    logic [3:0]  router;
    logic [1:0]  eth;
    logic        milbus;
    logic [DBIM_NSTAT-1:0] stat;
    logic        scrub;
    logic        l2;
    logic [1:0]  uart;
    logic        iommu;
  } dbim_irq_src_s;

  localparam int DBIM_IRQ_TMR0   = 1;
  localparam int DBIM_IRQ_TMR1   = 6;
  localparam int DBIM_IRQ_EXT    = 10;
  localparam int DBIM_IRQ_PCI    = 11;
  localparam int DBIM_IRQ_NMI    = 15;
  localparam int DBIM_IRQ_GPIO   = 16;
  localparam int DBIM_IRQ_SPI    = 19;
  localparam int DBIM_IRQ_ROUTER = 20;
  localparam int DBIM_IRQ_ETH    = 24;
  localparam int DBIM_IRQ_MILBUS = 26;
  localparam int DBIM_IRQ_STAT   = 27;
  localparam int DBIM_IRQ_SCRUB  = 28;
  localparam int DBIM_IRQ_UART   = 29;
  localparam int DBIM_IRQ_IOMMU  = 31;
  localparam int DBIM_TMR_UNITS  = 4;
  localparam int DBIM_TMR_PER    = 4;

endpackage

// ===== verilog/dbim_irq_map.sv
`timescale 1ns/1ps

// Routes peripheral interrupt requests onto the numbered lines that the
// multiprocessor interrupt controller presents to the processors.
module dbim_irq_map
  import dbim_pkg::*;
(
  input  wire logic          i_clock,   // System clock.
  input  wire logic          i_rst_b,   // Asynchronous reset, active low.
  input  wire logic          i_clk_en,  // Freezes the lines while low.
  input  wire dbim_irq_src_s i_src,     // Peripheral requests.
  output logic [31:0]        o_irq      // Registered interrupt lines.
);

  //////////////////////////////////////////////////////////////////////////////
  // Line assembly.
  //////////////////////////////////////////////////////////////////////////////

  logic [31:0]               irq_r;     // Registered lines.
  logic [31:0]               irq_nxt;   // Next value of the lines.
  logic [DBIM_TMR_UNITS-1:0] tmr_shr;   // One shared line per timer unit.

  // Each of timer units 1 to 4 folds its timers onto one line.
  genvar g;
  generate
    for (g = 0; g < DBIM_TMR_UNITS; g++)
    begin : g_tmr
      assign tmr_shr[g] = |i_src.tmr14[g*DBIM_TMR_PER +: DBIM_TMR_PER];
    end
  endgenerate

  // Map each source to its line; lines 0, 12, 13, 14 and 15 stay low
  // because no peripheral owns them.  Line 15 is the unmaskable one, so
  // tying it low keeps a stray source from forcing a processor trap.
  always_comb
  begin
    irq_nxt = 32'h0000_0000;
    irq_nxt[DBIM_IRQ_TMR0 +: 5] = i_src.tmr0;
    irq_nxt[DBIM_IRQ_TMR1 +: DBIM_TMR_UNITS] = tmr_shr;
    irq_nxt[DBIM_IRQ_PCI] = i_src.pci | i_src.pcidma;
    irq_nxt[DBIM_IRQ_NMI] = 1'b0;
    irq_nxt[DBIM_IRQ_GPIO +: 4] = i_src.gpio;
    irq_nxt[DBIM_IRQ_SPI] = i_src.gpio[3] | i_src.spi;
    irq_nxt[DBIM_IRQ_ROUTER +: 4] = i_src.router;
    irq_nxt[DBIM_IRQ_ETH +: 2] = i_src.eth;
    irq_nxt[DBIM_IRQ_MILBUS] = i_src.milbus;
    irq_nxt[DBIM_IRQ_STAT] = |i_src.stat;
    irq_nxt[DBIM_IRQ_SCRUB] = i_src.scrub | i_src.l2;
    irq_nxt[DBIM_IRQ_UART +: 2] = i_src.uart;
    irq_nxt[DBIM_IRQ_IOMMU] = i_src.iommu;
    // The extended line follows the same cycle as lines 15 to 31.
    irq_nxt[DBIM_IRQ_EXT] = |irq_nxt[31:DBIM_IRQ_NMI];
  end

  // Register the lines so that every output comes from a flip-flop.
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
      irq_r <= 32'h0000_0000;
    else if (i_clk_en)
      irq_r <= irq_nxt;
  end

  assign o_irq = irq_r;

endmodule

// ===== testbench/dbim_periph.sv
`timescale 1ns/1ps

// Far-side peripherals: raise one request line chosen by index.
// Index 42 raises every source at once; any higher index raises none.
module dbim_periph
  import dbim_pkg::*;
(
  input  wire logic    i_clock,  // System clock.
  input  wire logic [5:0] i_sel, // Source index to raise.
  output dbim_irq_src_s o_src    // Level requests toward the block.
);
  initial o_src = '0;
  // No source is wired to lines 12 to 14; they stay free for software.
  always @(posedge i_clock)
    o_src <= (i_sel == 6'h2a) ? '1 : dbim_irq_src_s'(42'h1 << i_sel);
endmodule

// ===== testbench/dbim_top_monitor.sv
`timescale 1ns/1ps

module dbim_top_monitor
  import dbim_pkg::*;
(
  input wire logic          i_clock,
  input wire logic          i_rst_b,
  input wire logic          i_clk_en,
  input wire dbim_req_s     i_req,
  input wire dbim_irq_src_s i_irq_src,
  input wire dbim_dec_s     o_dec,
  input wire logic [31:0]   o_irq
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  // A legal request from a debug-bus master.
  sequence s_dbg_req;
    i_clk_en && i_req.vld && i_req.bus == DBIM_BUS_DBG &&
      i_req.mst < DBIM_NMST_DBG;
  endsequence
  a_win_guard: assert property (
    i_clk_en && i_req.vld && i_req.bus != DBIM_BUS_DBG &&
    i_req.addr[31:28] == 4'he |=> o_dec.err && o_dec.tgt == DBIM_T_NONE)
    else $error("debug window open to non-debug master");
  a_dsu_hit: assert property (
    s_dbg_req ##0 (i_req.addr[31:26] == 6'h38 && !i_req.addr[23])
    |=> o_dec.tgt == DBIM_T_DSU && o_dec.unit == $past(i_req.addr[25:24]))
    else $error("debug unit region decoded wrongly");
  a_trace_hit: assert property (
    s_dbg_req ##0 (i_req.addr >= DBIM_TRACE_LO &&
    i_req.addr <= DBIM_TRACE_HI) |=> o_dec.tgt == DBIM_T_TRACE)
    else $error("trace buffer range missed");
  a_ext_line: assert property (
    o_irq[10] == (|o_irq[31:15])) else $error("line 10 not the OR");
  a_free_lines: assert property (
    o_irq[15:12] == 4'h0 && !o_irq[0]) else $error("free line driven");
  a_timer_lines: assert property (
    i_clk_en |=> o_irq[5:1] == $past(i_irq_src.tmr0))
    else $error("timer lines 1-5 wrong");
  a_pci_line: assert property (
    i_clk_en |=> o_irq[11] == $past(i_irq_src.pci | i_irq_src.pcidma))
    else $error("line 11 wrong");
  // A low enable must freeze both outputs.
  a_hold_frozen: assert property (
    !i_clk_en |=> $stable(o_irq) && $stable(o_dec))
    else $error("outputs moved while frozen");
endmodule

bind dbim_top dbim_top_monitor i_mon (.i_clock(i_clock), .i_rst_b(i_rst_b),
  .i_clk_en(i_clk_en), .i_req(i_req), .i_irq_src(i_irq_src),
  .o_dec(o_dec), .o_irq(o_irq));

// ===== testbench/tb.sv
`timescale 1ns/1ps

module tb
  import dbim_pkg::*;
;
  logic          i_clock = 1'b0;  // 100 MHz clock.
  logic          i_rst_b = 1'b0;  // Reset, active low.
  logic          i_clk_en = 1'b1; // Run enable.
  dbim_req_s     i_req = '0;      // Decode request.
  logic [5:0]    sel = 6'h3f;     // Peripheral source index.
  dbim_irq_src_s src;             // Requests from the peripherals.
  dbim_dec_s     o_dec;
  logic [31:0]   o_irq;
  int            error_cnt = 0;
  int            samples_checked = 0;
  int            cyc = 0;

  always #5 i_clock = ~i_clock;
  dbim_periph i_per (.i_clock(i_clock), .i_sel(sel), .o_src(src));
  dbim_top i_dut (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_clk_en(i_clk_en),
    .i_req(i_req), .i_irq_src(src), .o_dec(o_dec), .o_irq(o_irq));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Cuts a hang short; the whole run needs a few hundred cycles.
  always @(posedge i_clock)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      error_cnt++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // One decode; e is {err, target}, l[8] asks for {unit, rec, slv}.
  task automatic dec(input dbim_bus_e b, input logic [3:0] m,
    input logic [31:0] a, input logic [5:0] e, input logic [8:0] l);
    @(posedge i_clock) i_req <= '{1'b1, b, m, a};
    @(posedge i_clock) #1;
    chk({o_dec.vld, o_dec.err, o_dec.tgt}, {1'b1, e});
    if (l[8]) chk({o_dec.unit, o_dec.rec, o_dec.slv}, l[7:0]);
  endtask
  // Expected lines for source index k, counted from the struct's lsb.
  function automatic logic [31:0] exp_irq(input int k);
    int n;
    if (k == 42) return 32'hffff_0ffe;
    n = k < 1 ? 31 : k < 3 ? 28 + k : k < 5 ? 28 : k < 7 ? 27 :
      k == 7 ? 26 : k < 10 ? 16 + k : k < 14 ? 10 + k : k == 14 ? 19 :
      k < 19 ? k + 1 : k < 21 ? 11 : k < 37 ? 6 + (k - 21) / 4 : k - 36;
    return (32'h1 << n) | (n >= 15 ? 32'h400 : 32'h0);
  endfunction
  task automatic t_decode();
    dec(DBIM_BUS_PROC, 4'h0, 32'he000_0000, 6'h20, 9'h0);
    dec(DBIM_BUS_MIO, 4'h8, 32'he400_0000, 6'h20, 9'h0);
    dec(DBIM_BUS_DBG, 4'h4, 32'hffe0_0000, DBIM_T_SDRAM, 9'h0);
    dec(DBIM_BUS_DBG, 4'h1, 32'he100_0010, DBIM_T_DSU, 9'h106);
    dec(DBIM_BUS_DBG, 4'h0, 32'he37f_ffff, DBIM_T_DSU, 9'h10e);
    dec(DBIM_BUS_DBG, 4'h0, 32'he080_0000, 6'h20, 9'h0);
    dec(DBIM_BUS_DBG, 4'h2, 32'he400_00ff, DBIM_T_DSPW, 9'h0);
    dec(DBIM_BUS_DBG, 4'h2, 32'he400_0100, DBIM_T_DSTAT, 9'h0);
    dec(DBIM_BUS_DBG, 4'h3, 32'he407_ffff, DBIM_T_DPTRC, 9'h0);
    dec(DBIM_BUS_DBG, 4'h3, 32'he400_0200, 6'h20, 9'h0);
    dec(DBIM_BUS_DBG, 4'h0, 32'heff1_ffff, DBIM_T_TRACE, 9'h0);
    dec(DBIM_BUS_DBG, 4'h0, 32'heff2_0000, 6'h20, 9'h0);
    dec(DBIM_BUS_DBG, 4'h0, 32'he40f_ff00, DBIM_T_DAPNP, 9'h0);
    dec(DBIM_BUS_DBG, 4'h0, 32'hefff_f080, DBIM_T_DBGPNP, 9'h112);
    dec(DBIM_BUS_DBG, 4'h0, 32'hefff_f0a0, DBIM_T_DBGPNP, 9'h114);
    dec(DBIM_BUS_DBG, 4'h0, 32'hefff_f860, DBIM_T_DBGPNP, 9'h10f);
    dec(DBIM_BUS_DBG, 4'h0, 32'he40f_f010, DBIM_T_DAPNP, 9'h10a);
    dec(DBIM_BUS_DBG, 4'h0, 32'he40f_f018, 6'h20, 9'h0);
    dec(DBIM_BUS_MEM, 4'h1, 32'hffe0_10ff, DBIM_T_SCRUB, 9'h0);
    dec(DBIM_BUS_MEM, 4'h1, 32'hffe0_1100, 6'h20, 9'h0);
    dec(DBIM_BUS_MEM, 4'h2, 32'hffef_f040, DBIM_T_MEMPNP, 9'h10a);
    dec(DBIM_BUS_PROC, 4'h5, 32'hffff_ffff, DBIM_T_PRCPNP, 9'h0);
    dec(DBIM_BUS_PROC, 4'h0, 32'hffaf_f000, DBIM_T_APB1PNP, 9'h0);
    dec(DBIM_BUS_PROC, 4'h0, 32'hf040_0000, 6'h20, 9'h0);
    dec(DBIM_BUS_MIO, 4'h8, 32'h0000_0000, DBIM_T_L2MEM, 9'h0);
    dec(DBIM_BUS_MIO, 4'h9, 32'h0000_0000, 6'h20, 9'h0);
    @(posedge i_clock) i_req.vld <= 1'b0;
    // A request that is not valid must leave a cleared result behind.
    @(posedge i_clock) #1 chk({17'h0, o_dec}, 32'h0);
    $display("decode test done");
  endtask
  // Each source alone, then all together, then a frozen change.
  task automatic t_irq();
    for (int k = 0; k <= 42; k++)
    begin
      @(posedge i_clock) sel <= 6'(k);
      repeat (2) @(posedge i_clock);
      #1 chk(o_irq, exp_irq(k));
    end
    @(posedge i_clock) sel <= 6'h3f;
    repeat (3) @(posedge i_clock);
    i_clk_en <= 1'b0;
    sel <= 6'h2a;
    // A decode offered while frozen must not reach the result early.
    i_req <= '{1'b1, DBIM_BUS_DBG, 4'h0, DBIM_TRACE_LO};
    repeat (3) @(posedge i_clock);
    #1 chk(o_irq, 32'h0);
    chk({17'h0, o_dec}, 32'h0);
    @(posedge i_clock) i_clk_en <= 1'b1;
    @(posedge i_clock) #1 chk(o_irq, 32'hffff_0ffe);
    chk({o_dec.vld, o_dec.err, o_dec.tgt}, {2'b10, DBIM_T_TRACE});
    @(posedge i_clock) i_req.vld <= 1'b0;
    $display("interrupt test done");
  endtask

  initial
  begin
    repeat (3) @(posedge i_clock);
    #1 chk({17'h0, o_dec}, 32'h0);
    chk(o_irq, 32'h0);
    @(posedge i_clock) i_rst_b <= 1'b1;
    t_decode();
    t_irq();
    complete_run();
  end
endmodule
